// ### brms_pkg.sv
// Constants and types for the bus-rights mode selection block.
// Assumes one 125 MHz system clock and a synchronous active-high reset.
//
// Summary of operation
// R1: Boot space width from two pins: 00=8, 01=16, 10=32, 11 forbidden.
// R2: Surroundings keep both boot width pins stable while the device runs.
// R3: Slave-select pin high puts device in total slave mode, share bit ignored.
// R4: Slave-select low with share bit set gives partial-share master mode.
// R5: Slave-select low with share bit clear gives total master mode.
// R6: Total master owns the bus and accesses anything without requesting.
// R7: Total master hands the bus to another CPU that requests it.
// R8: Total slave requests and waits for grant; master must answer with grant.
// R9: Partial-share master requests and waits for grant before shared space.
// R10: Partial-share master reaches spaces zero, one, three without a request.
// R11: Surroundings keep slave-select pin still during any external access.
// R12: Granted device holds bus until access completes, then drops its request.
package brms_pkg;

  // ****************************************************************
  // Encodings
  // ****************************************************************
  localparam logic [1:0] WIDTH_SEL_8 = 2'h0;
  localparam logic [1:0] WIDTH_SEL_16 = 2'h1;
  localparam logic [1:0] WIDTH_SEL_32 = 2'h2;
  localparam logic [1:0] WIDTH_SEL_BAD = 2'h3;

  localparam logic [1:0] SPACE_BOOT = 2'h0;
  localparam logic [1:0] SPACE_ONE = 2'h1;
  localparam logic [1:0] SPACE_SHARED = 2'h2;
  localparam logic [1:0] SPACE_THREE = 2'h3;

  // Bus width code driven out: one-hot 8/16/32
  localparam logic [2:0] BUS_W8 = 3'h1;
  localparam logic [2:0] BUS_W16 = 3'h2;
  localparam logic [2:0] BUS_W32 = 3'h4;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_TOTAL_MASTER,
    MODE_PARTIAL_SHARE,
    MODE_TOTAL_SLAVE
  } brms_mode_e;

  typedef enum logic [1:0] {
    ARB_IDLE,
    ARB_REQ,
    ARB_OWN,
    ARB_LENT
  } brms_arb_e;

endpackage : brms_pkg

// ### brms_sync.sv
// Three-stage synchroniser with agreement of the last two stages.
// Assumes the input is a slow level from a pin or another device.
`timescale 1ns/100ps
module brms_sync (
  // Clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // Data
  input wire logic d_i,
  output logic q_o
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } brms_sync_s;

  brms_sync_s st_r;
  brms_sync_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = d_i;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // Only a settled level counts
    if (st_r.s2 == st_r.s3) begin
      st_nxt.q = st_r.s3;
    end
    if (srst_i) begin
      st_nxt = '0;
    end
  end

  always_ff @(posedge clock_i) begin
    st_r <= st_nxt;
  end

  assign q_o = st_r.q;

endmodule // brms_sync

// ### brms_mode_select.sv
// Mode selection and bus-rights arbitration for the external bus.
// Assumes mode pins are static straps and the access engine holds
// its request until done is seen.
`timescale 1ns/100ps
module brms_mode_select (
  // Clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // Mode pins
  input wire logic boot_width_sel_lo_i,
  input wire logic boot_width_sel_hi_i,
  input wire logic slave_select_pin_i,
  // Bus control register one share bit
  input wire logic partial_share_bit_i,
  // Access engine side
  input wire logic acc_req_i,
  input wire logic [1:0] acc_space_i,
  input wire logic acc_done_i,
  output logic acc_go_o,
  // Bus rights link to other CPU
  input wire logic other_req_i,
  output logic other_ack_o,
  output logic bus_req_o,
  input wire logic bus_grant_i,
  // Status
  output logic [2:0] boot_width_o,
  output logic width_bad_o,
  output logic [1:0] mode_o,
  output logic owns_bus_o
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic wlo_s;
  logic whi_s;
  logic slv_s;
  logic oreq_s;
  logic gnt_s;
  logic [4:0] raw_pins;
  logic [4:0] syn_pins;

  assign raw_pins = {boot_width_sel_lo_i, boot_width_sel_hi_i,
                     slave_select_pin_i, other_req_i, bus_grant_i};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      brms_sync u_sync (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .d_i(raw_pins[gi]),
        .q_o(syn_pins[gi])
      );
    end
  endgenerate

  assign {wlo_s, whi_s, slv_s, oreq_s, gnt_s} = syn_pins;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    brms_pkg::brms_arb_e arb;
    brms_pkg::brms_mode_e mode;
    logic [2:0] width;
    logic width_bad;
    logic bus_req;
    logic other_ack;
  } brms_state_s;

  brms_state_s st_r;
  brms_state_s st_nxt;

  logic need_grant;
  brms_pkg::brms_mode_e mode_now;

  always_comb begin
    // Mode decode; pin wins over share bit
    if (slv_s) begin
      mode_now = brms_pkg::MODE_TOTAL_SLAVE; // [R3]
    end else if (partial_share_bit_i) begin
      mode_now = brms_pkg::MODE_PARTIAL_SHARE; // [R4]
    end else begin
      mode_now = brms_pkg::MODE_TOTAL_MASTER; // [R5]
    end
    // Who must ask before touching the bus
    unique case (st_r.mode)
      brms_pkg::MODE_TOTAL_SLAVE: need_grant = 1'b1; // [R8]
      brms_pkg::MODE_PARTIAL_SHARE:
        need_grant = (acc_space_i == brms_pkg::SPACE_SHARED); // [R9] [R10]
      default: need_grant = 1'b0; // [R6]
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.mode = mode_now;
    // Width follows straps; forbidden code flagged, narrowest kept
    unique case ({whi_s, wlo_s}) // [R1]
      brms_pkg::WIDTH_SEL_8: st_nxt.width = brms_pkg::BUS_W8;
      brms_pkg::WIDTH_SEL_16: st_nxt.width = brms_pkg::BUS_W16;
      brms_pkg::WIDTH_SEL_32: st_nxt.width = brms_pkg::BUS_W32;
      brms_pkg::WIDTH_SEL_BAD: st_nxt.width = brms_pkg::BUS_W8;
    endcase
    st_nxt.width_bad = ({whi_s, wlo_s} == brms_pkg::WIDTH_SEL_BAD);

    unique case (st_r.arb)
      brms_pkg::ARB_IDLE: begin
        if (st_r.mode == brms_pkg::MODE_TOTAL_MASTER && oreq_s) begin
          st_nxt.arb = brms_pkg::ARB_LENT; // [R7]
          st_nxt.other_ack = 1'b1;
        end else if (acc_req_i && need_grant) begin
          st_nxt.arb = brms_pkg::ARB_REQ; // [R8] [R9]
          st_nxt.bus_req = 1'b1;
        end else if (acc_req_i) begin
          st_nxt.arb = brms_pkg::ARB_OWN; // [R6] [R10]
        end
      end
      brms_pkg::ARB_REQ: begin
        if (gnt_s) begin
          st_nxt.arb = brms_pkg::ARB_OWN; // [R8]
        end
      end
      brms_pkg::ARB_OWN: begin
        // Keep the bus until the access ends, then drop request
        if (acc_done_i) begin
          st_nxt.arb = brms_pkg::ARB_IDLE; // [R12]
          st_nxt.bus_req = 1'b0;
        end
      end
      brms_pkg::ARB_LENT: begin
        // Bus returns only when the borrower drops its request
        if (!oreq_s) begin
          st_nxt.arb = brms_pkg::ARB_IDLE; // [R7]
          st_nxt.other_ack = 1'b0;
        end
      end
    endcase

    if (srst_i) begin
      st_nxt.arb = brms_pkg::ARB_IDLE;
      st_nxt.mode = brms_pkg::MODE_TOTAL_MASTER;
      st_nxt.width = brms_pkg::BUS_W8;
      st_nxt.width_bad = 1'b0;
      st_nxt.bus_req = 1'b0;
      st_nxt.other_ack = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    st_r <= st_nxt;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign acc_go_o = (st_r.arb == brms_pkg::ARB_OWN);
  assign owns_bus_o = (st_r.arb == brms_pkg::ARB_OWN);
  assign other_ack_o = st_r.other_ack;
  assign bus_req_o = st_r.bus_req;
  assign boot_width_o = st_r.width;
  assign width_bad_o = st_r.width_bad;
  assign mode_o = st_r.mode;

endmodule // brms_mode_select

// ### brms_assertions.sv
// Checker for the mode select block.
// Assumes binding to the top module ports.
`timescale 1ns/100ps
module brms_assertions (
  // Clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // Inputs
  input wire logic slave_select_pin_i,
  input wire logic partial_share_bit_i,
  input wire logic acc_req_i,
  input wire logic [1:0] acc_space_i,
  input wire logic acc_done_i,
  input wire logic other_req_i,
  // Outputs
  input wire logic acc_go_o,
  input wire logic other_ack_o,
  input wire logic bus_req_o,
  input wire logic [2:0] boot_width_o,
  input wire logic width_bad_o,
  input wire logic [1:0] mode_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  a_bad_width: assert property (width_bad_o |-> boot_width_o == 3'h1)
    else $error("bad width code not 8 bits");
  a_slave_mode: assert property
    (slave_select_pin_i [*7] |-> mode_o == 2'h2)
    else $error("slave pin not giving slave mode");
  a_share_mode: assert property
    ((!slave_select_pin_i && partial_share_bit_i) [*7] |-> mode_o == 2'h1)
    else $error("share mode wrong");
  a_direct_go: assert property
    (acc_req_i && !acc_go_o && !other_ack_o && !other_req_i
    && (mode_o == 2'h0 || mode_o == 2'h1 && acc_space_i != 2'h2)
    |=> acc_go_o && !bus_req_o) else $error("direct access not started");
  a_req_first: assert property (acc_req_i && !acc_go_o && !bus_req_o
    && (mode_o == 2'h2 || mode_o == 2'h1 && acc_space_i == 2'h2)
    |=> bus_req_o && !acc_go_o) else $error("request missing before access");
  a_done_frees: assert property (acc_go_o && acc_done_i
    |=> !acc_go_o && !bus_req_o) else $error("bus kept after done");
  a_lend_bus: assert property ($rose(other_req_i) && mode_o == 2'h0
    && !acc_req_i && !acc_go_o |-> ##[2:6] other_ack_o)
    else $error("bus not lent");
  a_no_lend: assert property (other_ack_o |-> mode_o == 2'h0)
    else $error("lent bus outside total master");
endmodule // brms_assertions

// ### brms_master_model.sv
// Master CPU model: grants the bus after a set delay.
// Assumes req_i is the block's bus request.
`timescale 1ns/100ps
module brms_master_model (
  // Clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // Bus rights
  input wire logic req_i,
  input wire logic [3:0] dly_i,
  output logic grant_o
);
  logic [3:0] cnt_r;
  // Grant held until request falls, so no access is cut short
  always_ff @(posedge clock_i) begin
    cnt_r <= (srst_i || !req_i) ? 4'h0 : cnt_r + {3'h0, cnt_r != dly_i};
    grant_o <= !srst_i && req_i && cnt_r == dly_i;
  end
endmodule // brms_master_model

// ### tb.sv
// Bench for the mode select block.
// Assumes pins change only under reset.
`timescale 1ns/100ps
module tb;
  logic clock_i = 1'h0;
  logic srst_i = 1'h1;
  logic boot_width_sel_lo_i = 1'h0, boot_width_sel_hi_i = 1'h0;
  logic slave_select_pin_i = 1'h0, partial_share_bit_i = 1'h0;
  logic acc_req_i = 1'h0, acc_done_i = 1'h0, other_req_i = 1'h0;
  logic [1:0] acc_space_i = 2'h0, mode_o;
  logic bus_grant_i, acc_go_o, other_ack_o, bus_req_o, width_bad_o, owns_bus_o;
  logic [2:0] boot_width_o;
  logic [3:0] dly = 4'h1;
  int errors = 0, n_compared = 0;
  always #4 clock_i = ~clock_i;
  brms_mode_select uut (.*);
  brms_master_model mst (.clock_i(clock_i), .srst_i(srst_i),
    .req_i(bus_req_o), .dly_i(dly), .grant_o(bus_grant_i));
  task automatic check(input logic [2:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Straps only move under reset, never mid-access
  task automatic rst(input logic [3:0] pins);
    @(posedge clock_i);
    {boot_width_sel_hi_i, boot_width_sel_lo_i, slave_select_pin_i,
      partial_share_bit_i} <= pins;
    srst_i <= 1'h1;
    repeat (4) @(posedge clock_i);
    srst_i <= 1'h0;
    repeat (8) @(posedge clock_i);
    // Outputs are read between edges, where they are settled
    @(negedge clock_i);
  endtask
  task automatic access(input logic [1:0] sp, input logic want);
    int i;
    @(posedge clock_i);
    acc_req_i <= 1'h1;
    acc_space_i <= sp;
    for (i = 0; i < 40 && acc_go_o !== 1'h1; i++) @(negedge clock_i);
    check(acc_go_o, 3'h1);
    check(owns_bus_o, 3'h1);
    check(bus_req_o, want);
    @(negedge clock_i);
    check(bus_req_o, want);
    @(posedge clock_i);
    acc_done_i <= 1'h1;
    acc_req_i <= 1'h0;
    @(posedge clock_i);
    acc_done_i <= 1'h0;
    @(negedge clock_i);
    check({acc_go_o, bus_req_o}, 3'h0);
    // Let the old grant drain through its synchroniser
    repeat (8) @(posedge clock_i);
  endtask
  initial begin
    int c, m, s;
    for (c = 0; c < 4; c++) begin
      rst({c[1:0], 2'h0});
      check(boot_width_o, c == 3 ? 3'h1 : 3'h1 << c);
      check(width_bad_o, c == 3);
    end
    $display("width test done");
    for (m = 0; m < 4; m++) begin
      dly <= m[0] ? 4'hc : 4'h1;
      rst({2'h0, m[1:0]});
      check(mode_o, m[1] ? 3'h2 : {2'h0, m[0]});
      for (s = 0; s < 4; s++)
        access(s[1:0], m[1] || (m[0] && s == 2));
      other_req_i <= 1'h1;
      repeat (8) @(posedge clock_i);
      @(negedge clock_i);
      check(other_ack_o, m == 0);
      @(posedge clock_i);
      other_req_i <= 1'h0;
      repeat (8) @(posedge clock_i);
      @(negedge clock_i);
      check(other_ack_o, 3'h0);
      $display("mode test %0d done", m);
    end
    tally_and_finish;
  end
  initial begin
    #40000;
    errors++;
    tally_and_finish;
  end
endmodule // tb
bind brms_mode_select brms_assertions chk (.*);
